//--- design/cmd_unit_map.vh
/*
  constants of the serial command unit: command codes, field positions,
  reset values and timing figures.
  assumes a 250 MHz system clock.
*/
`ifndef CMD_UNIT_MAP_VH
`define CMD_UNIT_MAP_VH

`define CLK_MHZ            250
`define WR_SAVE_SEL        7'h72
`define RD_SAVE_SEL        7'h33
`define WR_CONF_ONE        7'h74
`define RD_CONF_ONE        7'h34
`define WR_CONF_TWO        7'h75
`define RD_CONF_TWO        7'h35
`define WR_NODE_ADDR       7'h7c
`define WR_CUR_CAL         7'h7d
`define RD_FW_REV          7'h3e
`define RD_BOARD_REV       7'h3f
`define ADDR_FLAG          8'h80
`define NODE_ADDR_RST      7'h00
`define CONF_RST           14'h0000
`define SAVE_SEL_BITS      5
`define FD_BIT             9
`define DM_BIT             4
`define BM_BIT             3
`define SRC_HI             2
`define SRC_LO             1
`define UC_BIT             0
`define TOPS_BIT           8
`define POFF_BIT           7
`define USP_HI             2
`define USP_LO             1
`define CONF_ONE_MASK      14'h021f
`define CONF_TWO_MASK      14'h0186
`define SRC_NONE           2'b00
`define SRC_SHORT          2'b01
`define TIMEOUT_SHORT_MS   50
`define TIMEOUT_LONG_MS    2800
`define BAUD_DEFAULT       19200
`define CAL_TOL_PCT        20

`endif

//--- design/serial_config_command_unit.v
/*
  serial command unit of a motor speed controller: five byte write and two byte read addressed
  frames on a shared uart, configuration and save registers, version reads.
  assumes a 250 MHz clock, a synchronous rx line and an external flash
  engine that answers each save request with a done pulse.
*/
// Behaviour
// - write to save-select marks registers and starts the flash save at once
// - saved registers reload at restart and are locked against on-board controls; LOCK_O clears at reset and is set only by a save-select write
// - during a save pwm halts and no other command is served
// - save-select bits 4..0 choose pot max, pot min, top speed, IxR, calibration
// - config one bit 9: zero stop, one forward
// - config one bit 4: drive when zero, brake or coast when one
// - config one bit 3: zero coast, one automatic regeneration
// - auto brake regenerates when motor voltage exceeds commanded speed
// - config one bits 2:1 speed timeout: none, 50 ms, 2800 ms
// - config one bit 0 gates the configuration bits
// - config two: writing one clears a bit, zero leaves it
// - config two bit 8 enables top-speed supply compensation
// - config two bit 7 disables brake function of the pulse/brake pin
// - config two bits 2:1 baud code; 00 and default give 19200
// - 7-bit bus address, code 0x7c, default zero, saved and reloaded
// - device sends its address right after start
// - calibration write ignored when off internal measurement by over 20 percent
// - read-only 14-bit firmware and board revisions on 0x3e and 0x3f
// - read reply: address or 0x80, data high, data low, checksum with code
`timescale 1ns/1ps
`include "cmd_unit_map.vh"
module serial_config_command_unit #(
  parameter BAUD           = `BAUD_DEFAULT,
  parameter BIT_CYCLES     = `CLK_MHZ * 1000000 / `BAUD_DEFAULT,
  parameter SHORT_CYCLES   = `CLK_MHZ * 1000 * `TIMEOUT_SHORT_MS,
  parameter LONG_CYCLES    = `CLK_MHZ * 1000 * `TIMEOUT_LONG_MS,
  parameter [13:0] FW_REV    = 14'h0001, // arbitrary value
  parameter [13:0] BOARD_REV = 14'h0001  // arbitrary value
) (
  // clock and reset
  input  wire        MCLK_I,
  input  wire        RESET_I,
  // serial line
  input  wire        RXD_I,
  output reg         TXD_O,
  // flash side
  input  wire [6:0]  SAVED_ADDR_I,
  input  wire [13:0] SAVED_CONF_TWO_I,
  input  wire        SAVE_DONE_I,
  output reg         SAVE_START_O,
  output reg  [4:0]  SAVE_SELECT_O,
  output reg  [4:0]  LOCK_O,
  // measurement and speed control
  input  wire [13:0] CURRENT_MEAS_I,
  input  wire [13:0] MOTOR_VOLT_I,
  input  wire [13:0] SPEED_CMD_I,
  input  wire        SPEED_UPDATE_I,
  output reg  [13:0] CUR_CAL_O,
  output reg         CUR_CAL_STROBE_O,
  // drive controls
  output reg         PWM_HALT_O,
  output reg         FORWARD_O,
  output reg         DRIVE_BRAKE_O,
  output reg         REGEN_O,
  output reg         SPEED_RESET_O,
  output reg         TOP_SPEED_COMP_O,
  output reg         BRAKE_PIN_OFF_O,
  output reg  [1:0]  BAUD_CODE_O
);
  localparam ST_ADDR = 3'd0, ST_CMD = 3'd1, ST_DHI = 3'd2, ST_DLO = 3'd3, ST_SUM = 3'd4;

  wire [7:0] rx_data;
  wire       rx_valid;
  wire       tx_ready;
  reg  [7:0] tx_data;
  reg        tx_load;
  wire       txd;

  reg  [2:0]  state;
  reg         addr_hit;
  reg  [6:0]  cmd;
  reg  [6:0]  dhi;
  reg  [6:0]  dlo;
  reg  [4:0]  save_select;
  reg  [13:0] conf_one;
  reg  [13:0] conf_two;
  reg  [6:0]  node_addr;
  reg         saving;
  reg  [7:0]  reply [0:3];
  reg  [2:0]  reply_left;
  reg  [1:0]  reply_idx;
  reg         boot;
  reg  [31:0] idle_cnt;
  reg  [13:0] rd_val;

  wire [13:0] wr_val = {dhi, dlo};
  wire [6:0]  frame_sum = cmd + dhi + dlo;
  wire        cmd_is_read = ~cmd[6];
  wire [31:0] tol_full = (CURRENT_MEAS_I * `CAL_TOL_PCT) / 100;
  // 20 percent of a 14-bit value always fits in 16 bits
  wire [15:0] tol = tol_full[15:0];
  wire [15:0] cal_lo = {2'b00, CURRENT_MEAS_I} - tol;
  wire [15:0] cal_hi = {2'b00, CURRENT_MEAS_I} + tol;
  wire        cal_ok = ({2'b00, wr_val} >= cal_lo || tol > {2'b00, CURRENT_MEAS_I})
                       && {2'b00, wr_val} <= cal_hi;
  wire        gate = conf_one[`UC_BIT];

  serial_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .clk_i   (MCLK_I),
    .rst_i   (RESET_I),
    .rxd_i   (RXD_I),
    .data_o  (rx_data),
    .valid_o (rx_valid)
  );

  serial_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .clk_i   (MCLK_I),
    .rst_i   (RESET_I),
    .data_i  (tx_data),
    .load_i  (tx_load),
    .ready_o (tx_ready),
    .txd_o   (txd)
  );

  always @* begin
    case (cmd)
      `RD_SAVE_SEL:  rd_val = {9'h000, save_select};
      `RD_CONF_ONE:  rd_val = conf_one;
      `RD_CONF_TWO:  rd_val = conf_two;
      `RD_FW_REV:    rd_val = FW_REV;
      `RD_BOARD_REV: rd_val = BOARD_REV;
      default:       rd_val = 14'h0000;
    endcase
  end

  // frame parser and register writes
  always @(posedge MCLK_I) begin
    SAVE_START_O     <= 1'b0;
    CUR_CAL_STROBE_O <= 1'b0;
    tx_load          <= 1'b0;
    if (RESET_I) begin
      state       <= ST_ADDR;
      addr_hit    <= 1'b0;
      cmd         <= 7'h00;
      dhi         <= 7'h00;
      dlo         <= 7'h00;
      save_select <= 5'h00;
      conf_one    <= `CONF_RST;
      conf_two    <= `CONF_RST;
      node_addr   <= `NODE_ADDR_RST;
      saving      <= 1'b0;
      LOCK_O      <= 5'h00;
      CUR_CAL_O   <= 14'h0000;
      reply_left  <= 3'd0;
      reply_idx   <= 2'd0;
      boot        <= 1'b1;
      reply[0]    <= 8'h00;
      reply[1]    <= 8'h00;
      reply[2]    <= 8'h00;
      reply[3]    <= 8'h00;
    end else begin
      if (boot) begin
        // saved values reload one cycle after restart release
        boot       <= 1'b0;
        node_addr  <= SAVED_ADDR_I;
        conf_two   <= SAVED_CONF_TWO_I & `CONF_TWO_MASK;
        reply[0]   <= `ADDR_FLAG | {1'b0, SAVED_ADDR_I};
        reply_idx  <= 2'd0;
        reply_left <= 3'd1;
      end else if (reply_left != 3'd0 && tx_ready && !tx_load) begin
        tx_data    <= reply[reply_idx];
        tx_load    <= 1'b1;
        reply_idx  <= reply_idx + 2'd1;
        reply_left <= reply_left - 3'd1;
      end
      if (saving) begin
        if (SAVE_DONE_I)
          saving <= 1'b0;
        // bytes arriving mid-save are dropped; the parser restarts on a fresh address
        state <= ST_ADDR;
      end else if (rx_valid && !boot) begin
        if (rx_data[7]) begin
          addr_hit <= (rx_data[6:0] == node_addr);
          state    <= ST_CMD;
        end else begin
          case (state)
            ST_CMD: begin
              cmd   <= rx_data[6:0];
              state <= rx_data[6] ? ST_DHI : ST_ADDR;
              if (!rx_data[6] && addr_hit && reply_left == 3'd0) begin
                state <= ST_SUM;
              end
            end
            ST_DHI: begin
              dhi   <= rx_data[6:0];
              state <= ST_DLO;
            end
            ST_DLO: begin
              dlo   <= rx_data[6:0];
              state <= ST_SUM;
            end
            default: state <= ST_ADDR;
          endcase
        end
      end
      // read reply once the command byte is in
      if (!saving && state == ST_SUM && cmd_is_read) begin
        state      <= ST_ADDR;
        reply[0]   <= `ADDR_FLAG | {1'b0, node_addr};
        reply[1]   <= {1'b0, rd_val[13:7]};
        reply[2]   <= {1'b0, rd_val[6:0]};
        reply[3]   <= {1'b0, rd_val[13:7] + rd_val[6:0] + cmd};
        reply_idx  <= 2'd0;
        reply_left <= 3'd4;
      end
      if (!saving && rx_valid && !rx_data[7] && state == ST_SUM && !cmd_is_read) begin
        state <= ST_ADDR;
        if (addr_hit && rx_data[6:0] == frame_sum) begin
          case (cmd)
            `WR_SAVE_SEL: begin
              save_select <= wr_val[`SAVE_SEL_BITS-1:0];
              LOCK_O      <= LOCK_O | wr_val[`SAVE_SEL_BITS-1:0];
              saving      <= 1'b1;
              SAVE_START_O <= 1'b1;
            end
            `WR_CONF_ONE: conf_one <= wr_val & `CONF_ONE_MASK;
            `WR_CONF_TWO: conf_two <= conf_two & ~(wr_val & `CONF_TWO_MASK);
            `WR_NODE_ADDR: node_addr <= wr_val[6:0];
            `WR_CUR_CAL: begin
              if (cal_ok) begin
                CUR_CAL_O        <= wr_val;
                CUR_CAL_STROBE_O <= 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // speed update watchdog
  always @(posedge MCLK_I) begin
    if (RESET_I || SPEED_UPDATE_I || !gate)
      idle_cnt <= 32'h0000_0000;
    else if (idle_cnt != 32'hffff_ffff)
      idle_cnt <= idle_cnt + 32'h0000_0001;
  end

  // drive outputs
  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      TXD_O            <= 1'b1;
      SAVE_SELECT_O    <= 5'h00;
      PWM_HALT_O       <= 1'b0;
      FORWARD_O        <= 1'b0;
      DRIVE_BRAKE_O    <= 1'b0;
      REGEN_O          <= 1'b0;
      SPEED_RESET_O    <= 1'b0;
      TOP_SPEED_COMP_O <= 1'b0;
      BRAKE_PIN_OFF_O  <= 1'b0;
      BAUD_CODE_O      <= 2'b00;
    end else begin
      TXD_O            <= txd;
      SAVE_SELECT_O    <= save_select;
      PWM_HALT_O       <= saving;
      FORWARD_O        <= gate & conf_one[`FD_BIT];
      DRIVE_BRAKE_O    <= gate & conf_one[`DM_BIT];
      REGEN_O          <= gate & conf_one[`DM_BIT] & conf_one[`BM_BIT]
                          & (MOTOR_VOLT_I > SPEED_CMD_I);
      case (conf_one[`SRC_HI:`SRC_LO])
        `SRC_NONE:  SPEED_RESET_O <= 1'b0;
        `SRC_SHORT: SPEED_RESET_O <= gate && idle_cnt >= SHORT_CYCLES;
        default:    SPEED_RESET_O <= gate && idle_cnt >= LONG_CYCLES;
      endcase
      TOP_SPEED_COMP_O <= conf_two[`TOPS_BIT];
      BRAKE_PIN_OFF_O  <= conf_two[`POFF_BIT];
      BAUD_CODE_O      <= conf_two[`USP_HI:`USP_LO];
    end
  end
endmodule // serial_config_command_unit

//--- design/serial_rx.v
/*
  uart receiver, 8n1, lsb first, one byte pulse per character whose stop bit is high.
  assumes the line input is already synchronous to the clock.
*/
`timescale 1ns/1ps
module serial_rx #(
  parameter BIT_CYCLES = 13021
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // line
  input  wire       rxd_i,
  // byte out
  output reg  [7:0] data_o,
  output reg        valid_o
);
  reg [15:0] cnt;
  reg [3:0]  bitn;
  reg        busy;

  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (rst_i) begin
      cnt    <= 16'h0000;
      bitn   <= 4'h0;
      busy   <= 1'b0;
      data_o <= 8'h00;
    end else if (!busy) begin
      if (!rxd_i) begin
        busy <= 1'b1;
        bitn <= 4'h0;
        // sample mid-bit
        cnt  <= BIT_CYCLES[15:0] >> 1;
      end
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else begin
      cnt  <= BIT_CYCLES[15:0] - 16'h0001;
      bitn <= bitn + 4'h1;
      if (bitn == 4'h0 && rxd_i) begin
        busy <= 1'b0;
      end else if (bitn >= 4'h1 && bitn <= 4'h8) begin
        data_o <= {rxd_i, data_o[7:1]};
      end else if (bitn == 4'h9) begin
        busy    <= 1'b0;
        valid_o <= rxd_i;
      end
    end
  end
endmodule // serial_rx

//--- design/serial_tx.v
/*
  uart transmitter, 8n1, lsb first.
  assumes load_i is only given while ready_o is high.
*/
`timescale 1ns/1ps
module serial_tx #(
  parameter BIT_CYCLES = 13021
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // byte in
  input  wire [7:0] data_i,
  input  wire       load_i,
  output reg        ready_o,
  // line
  output reg        txd_o
);
  reg [15:0] cnt;
  reg [3:0]  bitn;
  reg [9:0]  shift;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt     <= 16'h0000;
      bitn    <= 4'h0;
      shift   <= 10'h3ff;
      ready_o <= 1'b1;
      txd_o   <= 1'b1;
    end else if (ready_o) begin
      if (load_i) begin
        shift   <= {1'b1, data_i, 1'b0};
        ready_o <= 1'b0;
        bitn    <= 4'h0;
        cnt     <= 16'h0000;
      end
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else if (bitn == 4'ha) begin
      ready_o <= 1'b1;
    end else begin
      txd_o <= shift[0];
      shift <= {1'b1, shift[9:1]};
      bitn  <= bitn + 4'h1;
      cnt   <= BIT_CYCLES[15:0] - 16'h0001;
    end
  end
endmodule // serial_tx

//--- test/cmd_unit_chk.sv
/* port assertions of the serial command unit.
   assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module cmd_unit_chk (
  input wire        MCLK_I,
  input wire        RESET_I,
  input wire        SAVE_DONE_I,
  input wire        SAVE_START_O,
  input wire [4:0]  SAVE_SELECT_O,
  input wire [4:0]  LOCK_O,
  input wire        PWM_HALT_O,
  input wire [13:0] CURRENT_MEAS_I,
  input wire [13:0] MOTOR_VOLT_I,
  input wire [13:0] SPEED_CMD_I,
  input wire [13:0] CUR_CAL_O,
  input wire        CUR_CAL_STROBE_O,
  input wire        REGEN_O,
  input wire        SPEED_RESET_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  a_start_one_pulse: assert property (SAVE_START_O |=> !SAVE_START_O)
    else $error("save start wider than one cycle");
  a_halt_follows: assert property (SAVE_START_O |-> ##[0:2] PWM_HALT_O)
    else $error("pwm not halted on save");
  a_halt_cause: assert property ($rose(PWM_HALT_O) |-> SAVE_START_O || $past(SAVE_START_O) ||
    $past(SAVE_START_O, 2)) else $error("halt without save start");
  a_halt_ends: assert property (PWM_HALT_O && SAVE_DONE_I |-> ##[1:3] !PWM_HALT_O)
    else $error("halt outlives save done");
  a_lock_sticky: assert property (1'b1 |=> (LOCK_O & $past(LOCK_O)) == $past(LOCK_O))
    else $error("lock bit dropped");
  a_lock_covers: assert property (SAVE_START_O |-> ##[0:2] (LOCK_O & SAVE_SELECT_O) == SAVE_SELECT_O)
    else $error("saved register not locked");
  a_regen_idle: assert property ((MOTOR_VOLT_I <= SPEED_CMD_I)[*3] |-> !REGEN_O)
    else $error("regen below commanded speed");
  a_cal_window: assert property (CUR_CAL_STROBE_O |-> CUR_CAL_O * 5 <= CURRENT_MEAS_I * 6 &&
    CUR_CAL_O * 5 >= CURRENT_MEAS_I * 4) else $error("calibration outside window");
  a_cal_steady: assert property (!CUR_CAL_STROBE_O |-> $stable(CUR_CAL_O))
    else $error("calibration changed without strobe");
  c_save: cover property (SAVE_START_O);
  c_cal: cover property (CUR_CAL_STROBE_O);
  c_regen: cover property (REGEN_O);
  c_sreset: cover property ($rose(SPEED_RESET_O));
endmodule // cmd_unit_chk

bind serial_config_command_unit cmd_unit_chk chk (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .SAVE_DONE_I(SAVE_DONE_I), .SAVE_START_O(SAVE_START_O),
  .SAVE_SELECT_O(SAVE_SELECT_O), .LOCK_O(LOCK_O), .PWM_HALT_O(PWM_HALT_O),
  .CURRENT_MEAS_I(CURRENT_MEAS_I), .MOTOR_VOLT_I(MOTOR_VOLT_I), .SPEED_CMD_I(SPEED_CMD_I),
  .CUR_CAL_O(CUR_CAL_O), .CUR_CAL_STROBE_O(CUR_CAL_STROBE_O), .REGEN_O(REGEN_O),
  .SPEED_RESET_O(SPEED_RESET_O)
);

//--- test/host_uart_model.sv
/* host end of the addressed serial link: sends 8n1 characters, decodes replies.
   assumes BIT clocks per bit both ways and an idle-high line. */
`timescale 1ns/1ps
module host_uart_model #(
  parameter BIT = 16
) (
  input  wire        clk_i,
  input  wire        txd_i,
  output logic       rxd_o,
  output logic [7:0] byte_o,
  output logic       valid_o
);
  logic [7:0] sh;
  initial begin
    rxd_o = 1'b1;
    byte_o = 8'h00;
    valid_o = 1'b0;
  end
  // stop bit leaves the line high, so it idles released between characters
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1 rxd_o = fr[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
  endtask
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      sh[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    #1 byte_o = sh;
    valid_o = 1'b1;
    @(posedge clk_i);
    #1 valid_o = 1'b0;
  end
endmodule // host_uart_model

//--- test/testbench.sv
/* self-checking bench of the serial command unit; the bench stands in for
   the flash engine and the measurement inputs. assumes the map header. */
`timescale 1ns/1ps
`include "cmd_unit_map.vh"
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rxd, txd, done, upd, start, stb, halt, fwd, brk, regen, sreset, tops, poff, rvalid;
  logic [6:0]  addr;
  logic [13:0] sconf, meas, volt, scmd, cal;
  logic [4:0]  sel, lock;
  logic [1:0]  baud;
  logic [7:0]  rbyte;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cycles = 0;

  serial_config_command_unit #(.BIT_CYCLES(16), .SHORT_CYCLES(50), .LONG_CYCLES(200),
    .FW_REV(14'h0123), .BOARD_REV(14'h0456)) dut (
    .MCLK_I(clk), .RESET_I(rst), .RXD_I(rxd), .TXD_O(txd), .SAVED_ADDR_I(addr),
    .SAVED_CONF_TWO_I(sconf), .SAVE_DONE_I(done), .SAVE_START_O(start), .SAVE_SELECT_O(sel),
    .LOCK_O(lock), .CURRENT_MEAS_I(meas), .MOTOR_VOLT_I(volt), .SPEED_CMD_I(scmd),
    .SPEED_UPDATE_I(upd), .CUR_CAL_O(cal), .CUR_CAL_STROBE_O(stb), .PWM_HALT_O(halt),
    .FORWARD_O(fwd), .DRIVE_BRAKE_O(brk), .REGEN_O(regen), .SPEED_RESET_O(sreset),
    .TOP_SPEED_COMP_O(tops), .BRAKE_PIN_OFF_O(poff), .BAUD_CODE_O(baud));
  // the model's default bit time already matches BIT_CYCLES above
  host_uart_model host (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .byte_o(rbyte),
    .valid_o(rvalid));

  always #2 clk = ~clk;

  task automatic report_and_stop();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the run is about 19000 cycles, so this ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // an unexpected reply byte meets an unknown note and so always mismatches
  always @(posedge clk)
    if (rvalid === 1'b1)
      check(rbyte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_q();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
      tick(1);
    check(16'(exp_q.size()), 0);
  endtask

  task automatic wr(input logic [6:0] a, c, input logic [13:0] d, input logic [6:0] bad);
    host.send({1'b1, a});
    host.send({1'b0, c});
    host.send({1'b0, d[13:7]});
    host.send({1'b0, d[6:0]});
    host.send({1'b0, 7'(c + d[13:7] + d[6:0] + bad)});
    tick(4);
  endtask

  task automatic rd(input logic [6:0] a, c, input logic [13:0] d);
    exp_q.push_back({1'b1, a});
    exp_q.push_back({1'b0, d[13:7]});
    exp_q.push_back({1'b0, d[6:0]});
    exp_q.push_back({1'b0, 7'(d[13:7] + d[6:0] + c)});
    host.send({1'b1, a});
    host.send({1'b0, c});
    wait_q();
  endtask

  initial begin
    void'($urandom(32'h4661f58e));
    addr = 7'($urandom());
    {done, upd, volt} = '0;
    sconf = 14'h0186;
    meas = 14'd100;
    scmd = 14'h3fff;
    exp_q.push_back({1'b1, addr});
    tick(10);
    rst = 1'b0;
    wait_q();
    $display("test boot done");
    wr(addr, `WR_CONF_ONE, 14'h0019, 0);
    check(brk, 1);
    check(fwd, 0);
    rd(addr, `RD_CONF_ONE, 14'h0019);
    volt = 14'd200;
    scmd = 14'd100;
    tick(5);
    check(regen, 1);
    volt = 14'd0;
    wr(addr, `WR_CONF_ONE, 14'h0203, 0);
    check(fwd, 1);
    check(brk, 0);
    repeat (10) begin
      upd = 1'b1;
      tick(1);
      upd = 1'b0;
      tick(20);
    end
    check(sreset, 0);
    tick(80);
    check(sreset, 1);
    wr(addr, `WR_CONF_ONE, 14'h0202, 0);
    check(fwd, 0);
    $display("test config one done");
    wr(addr, `WR_CONF_ONE, 14'($urandom()), 1);
    wr(addr + 7'd1, `WR_CONF_ONE, 14'h0019, 0);
    rd(addr, `RD_CONF_ONE, 14'h0202);
    $display("test refused frames done");
    rd(addr, `RD_CONF_TWO, 14'h0186);
    check(tops, 1);
    check(poff, 1);
    check(baud, 2'b11);
    wr(addr, `WR_CONF_TWO, 14'h0084, 0);
    check(poff, 0);
    check(baud, 2'b01);
    check(tops, 1);
    rd(addr, `RD_CONF_TWO, 14'h0102);
    rd(addr, `RD_FW_REV, 14'h0123);
    rd(addr, `RD_BOARD_REV, 14'h0456);
    $display("test config two done");
    wr(addr, `WR_CUR_CAL, 14'd121, 0);
    check(cal, 0);
    wr(addr, `WR_CUR_CAL, 14'd119, 0);
    check(cal, 119);
    wr(addr, `WR_CUR_CAL, 14'd79, 0);
    check(cal, 119);
    $display("test calibration done");
    // a single save keeps flash wear low
    wr(addr, `WR_SAVE_SEL, 14'h0015, 0);
    check(halt, 1);
    check(sel, 5'h15);
    check(lock, 5'h15);
    wr(addr, `WR_CONF_ONE, 14'h0019, 0);
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(3);
    check(halt, 0);
    rd(addr, `RD_CONF_ONE, 14'h0202);
    rd(addr, `RD_SAVE_SEL, 14'h0015);
    $display("test save done");
    wr(addr, `WR_NODE_ADDR, 14'h007f, 0);
    rd(7'h7f, `RD_CONF_ONE, 14'h0202);
    $display("test address done");
    report_and_stop();
  end
endmodule // testbench
